// file: bgc_consts.svh
`ifndef BGC_CONSTS_SVH
`define BGC_CONSTS_SVH
// register byte offsets
`define BGC_OFF_DEAD_TIME   12'h000
`define BGC_OFF_POLARITY    12'h004
`define BGC_OFF_HALL_CTRL   12'h008
`define BGC_OFF_SOFT_HALL   12'h00c
`define BGC_OFF_FILT_MODE   12'h010
`define BGC_OFF_FILT_COUNT  12'h014
`define BGC_OFF_STATUS      12'h018
`define BGC_OFF_TIMER_CMP   12'h01c
// dead time register fields
`define BGC_DT_COUNT_LSB    0
`define BGC_DT_ON_BIT       5
`define BGC_DT_DIV_LSB      6
// hall control fields
`define BGC_HC_DEC_ON_BIT   0
`define BGC_HC_SRC_BIT      3
`define BGC_HC_DLY_BIT      5
`define BGC_HC_TSEL_LSB     6
// filter mode fields
`define BGC_FM_RATE_LSB     0
`define BGC_FM_ON_BIT       4
// reset values
`define BGC_RST_DEAD_TIME   8'h00
`define BGC_RST_POLARITY    8'h00
`define BGC_RST_HALL_CTRL   8'h10
`define BGC_RST_TIMER_CMP   16'h0000
`endif

// file: bgc_pkg.sv
package bgc_pkg;
  typedef enum logic [2:0] {
    BGC_AX_IDLE = 3'b001,
    BGC_AX_WRSP = 3'b010,
    BGC_AX_RRSP = 3'b100
  } bgc_ax_t;
  typedef enum logic [1:0] {
    BGC_TM_FIRST10 = 2'b00,
    BGC_TM_SIXTEEN = 2'b01,
    BGC_TM_SECOND10 = 2'b10,
    BGC_TM_UNUSED  = 2'b11
  } bgc_tsel_t;
endpackage

// file: bgc_dead_time.sv
`timescale 1ns/100ps
`default_nettype none
module bgc_dead_time
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic       enable,
  input  wire logic [4:0] count,
  input  wire logic       phase_in,
  output logic            phase_out
);
  typedef struct packed {
    logic [5:0] cnt;
    logic       busy;
    logic       out;
  } bgc_dt_state_t;
  bgc_dt_state_t s_q;
  bgc_dt_state_t s_d;

  // rising edge waits count+1 ticks, falling passes at once
  always_comb
  begin
    s_d = s_q;
    if (!phase_in)
    begin
      s_d.out  = 1'b0;
      s_d.busy = 1'b0;
      s_d.cnt  = 6'h00;
    end
    else if (!enable)
    begin
      s_d.out  = 1'b1;
      s_d.busy = 1'b0;
    end
    else if (!s_q.out && !s_q.busy)
    begin
      s_d.busy = 1'b1;
      s_d.cnt  = 6'h00;
    end
    else if (s_q.busy && tick)
    begin
      if (s_q.cnt == {1'b0, count})
      begin
        s_d.out  = 1'b1;
        s_d.busy = 1'b0;
      end
      else
      begin
        s_d.cnt = s_q.cnt + 6'h01;
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign phase_out = s_q.out;
endmodule
`default_nettype wire

// file: bgc_top.sv
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "bgc_consts.svh"
module bgc_top
(
  input  wire logic        MCLK,
  input  wire logic        NRST,
  input  wire logic [11:0] AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [11:0] ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic [5:0]  PHASE_PRE,
  input  wire logic [2:0]  HALL_SENSOR_INPUTS,
  output logic [5:0]       GATE_OUT,
  output logic [5:0]       GATE_OE,
  output logic [2:0]       HALL_FILTERED,
  output logic [2:0]       HALL_DELAY_BUFFER_ONE,
  output logic [2:0]       HALL_DELAY_BUFFER_TWO,
  output logic             HALL_DECODER_ON,
  output logic             TIMER_DEDICATED,
  output logic [1:0]       TIMER_SEL,
  output logic             TIMER_RUN_BIT
);
  typedef struct packed {
    bgc_pkg::bgc_ax_t ax;
    logic             aw_got;
    logic             w_got;
    logic [11:0]      awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic [31:0]      rdata;
    logic [1:0]       resp;
    logic [7:0]       dead_time_setup;
    logic [7:0]       gate_polarity_control;
    logic [7:0]       hall_ctrl;
    logic [2:0]       soft_hall;
    logic [4:0]       hall_filter_mode_reg;
    logic [4:0]       hall_filter_match_count;
    logic [15:0]      timer_compare_a;
    logic             gates_live;
    logic [2:0]       div_cnt;
    logic [15:0]      rate_cnt;
    logic [2:0]       sync2;
    logic [2:0]       sync3;
    logic [2:0]       hall_stable;
    logic [2:0][4:0]  match_cnt;
    logic [2:0]       filtered;
    logic [2:0]       buf_one;
    logic [2:0]       buf_two;
    logic [15:0]      tmr;
    logic             tmr_run;
  } bgc_state_t;

  bgc_state_t s_q;
  bgc_state_t s_d;
  logic       rst_m_q;
  logic       rst_s_q;
  logic [2:0] sync1_q;
  logic       dt_tick;
  logic [5:0] dt_out;
  logic [5:0] stag;
  logic [2:0] hall_sel;
  logic [2:0] hall_src;
  logic       wr_go;

  // byte-lane merge for an 8-bit register
  function automatic logic [7:0] bgc_merge8(input logic [7:0] old, input logic [31:0] d,
                                            input logic [3:0] be);
    bgc_merge8 = be[0] ? d[7:0] : old;
  endfunction

  // reset release through two flip-flops
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end
    else
    begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // first sync stage for hall pins, read only by stage two
  always_ff @(posedge MCLK or negedge rst_s_q)
  begin
    if (!rst_s_q)
      sync1_q <= 3'h0;
    else
      sync1_q <= HALL_SENSOR_INPUTS;
  end

  // dead-time clock divider tick
  always_comb
  begin
    case (s_q.dead_time_setup[`BGC_DT_DIV_LSB +: 2])
      2'b00:   dt_tick = 1'b1;
      2'b01:   dt_tick = s_q.div_cnt[0] == 1'b1;
      2'b10:   dt_tick = s_q.div_cnt[1:0] == 2'b11;
      default: dt_tick = s_q.div_cnt == 3'h7;
    endcase
  end

  // six independent dead-time inserters
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_dt
      bgc_dead_time u_dt
      (
        .clk       (MCLK),
        .rst_n     (rst_s_q),
        .tick      (dt_tick),
        .enable    (s_q.dead_time_setup[`BGC_DT_ON_BIT]),
        .count     (s_q.dead_time_setup[`BGC_DT_COUNT_LSB +: 5]),
        .phase_in  (PHASE_PRE[gi]),
        .phase_out (dt_out[gi])
      );
    end
  endgenerate

  // staggered blocker per pair, then polarity, then pins
  always_comb
  begin
    for (int p = 0; p < 3; p++)
    begin
      stag[2*p]   = dt_out[2*p] & ~dt_out[2*p+1];
      stag[2*p+1] = dt_out[2*p+1] & ~dt_out[2*p];
    end
  end
  assign GATE_OUT = stag ^ s_q.gate_polarity_control[5:0];
  assign GATE_OE  = {6{s_q.gates_live}};

  // hall source select
  assign hall_sel = s_q.hall_stable;
  assign hall_src = s_q.hall_ctrl[`BGC_HC_SRC_BIT] ? hall_sel : s_q.soft_hall;

  assign wr_go = s_q.ax == bgc_pkg::BGC_AX_IDLE && s_q.aw_got && s_q.w_got;

  // next state of everything
  always_comb
  begin
    s_d = s_q;
    // axi write capture
    if (AWVALID && AWREADY)
    begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = AWADDR;
    end
    if (WVALID && WREADY)
    begin
      s_d.w_got = 1'b1;
      s_d.wdata = WDATA;
      s_d.wstrb = WSTRB;
    end
    case (s_q.ax)
      bgc_pkg::BGC_AX_IDLE:
      begin
        if (wr_go)
        begin
          s_d.aw_got = 1'b0;
          s_d.w_got  = 1'b0;
          s_d.ax     = bgc_pkg::BGC_AX_WRSP;
          s_d.resp   = 2'b00;
          case (s_q.awaddr)
            `BGC_OFF_DEAD_TIME:
              s_d.dead_time_setup = bgc_merge8(s_q.dead_time_setup, s_q.wdata, s_q.wstrb);
            `BGC_OFF_POLARITY:
            begin
              s_d.gate_polarity_control = bgc_merge8(s_q.gate_polarity_control, s_q.wdata,
                                                     s_q.wstrb) & 8'h3f;
              if (s_q.wstrb[0])
                s_d.gates_live = 1'b1;  // pins leave high impedance once set up
            end
            `BGC_OFF_HALL_CTRL:
              s_d.hall_ctrl = bgc_merge8(s_q.hall_ctrl, s_q.wdata, s_q.wstrb);
            `BGC_OFF_SOFT_HALL:
              if (s_q.wstrb[0])
                s_d.soft_hall = s_q.wdata[2:0];
            `BGC_OFF_FILT_MODE:
              if (s_q.wstrb[0])
                s_d.hall_filter_mode_reg = s_q.wdata[4:0];
            `BGC_OFF_FILT_COUNT:
              if (s_q.wstrb[0])
                s_d.hall_filter_match_count = s_q.wdata[4:0];
            `BGC_OFF_TIMER_CMP:
            begin
              if (s_q.wstrb[0])
                s_d.timer_compare_a[7:0] = s_q.wdata[7:0];
              if (s_q.wstrb[1])
                s_d.timer_compare_a[15:8] = s_q.wdata[15:8];
            end
            `BGC_OFF_STATUS:
              s_d.resp = 2'b10;
            default:
              s_d.resp = 2'b10;
          endcase
        end
        else if (ARVALID)
        begin
          s_d.ax    = bgc_pkg::BGC_AX_RRSP;
          s_d.resp  = 2'b00;
          s_d.rdata = 32'h0000_0000;
          case (ARADDR)
            `BGC_OFF_DEAD_TIME:  s_d.rdata[7:0] = s_q.dead_time_setup;
            `BGC_OFF_POLARITY:   s_d.rdata[7:0] = s_q.gate_polarity_control;
            `BGC_OFF_HALL_CTRL:  s_d.rdata[7:0] = s_q.hall_ctrl;
            `BGC_OFF_SOFT_HALL:  s_d.rdata[2:0] = s_q.soft_hall;
            `BGC_OFF_FILT_MODE:  s_d.rdata[4:0] = s_q.hall_filter_mode_reg;
            `BGC_OFF_FILT_COUNT: s_d.rdata[4:0] = s_q.hall_filter_match_count;
            `BGC_OFF_STATUS:     s_d.rdata[11:0] = {s_q.buf_two, s_q.buf_one, stag[5:4],
                                                    stag[3], s_q.filtered};
            `BGC_OFF_TIMER_CMP:  s_d.rdata[15:0] = s_q.timer_compare_a;
            default:             s_d.resp = 2'b10;
          endcase
        end
      end
      bgc_pkg::BGC_AX_WRSP:
        if (BREADY)
          s_d.ax = bgc_pkg::BGC_AX_IDLE;
      bgc_pkg::BGC_AX_RRSP:
        if (RREADY)
          s_d.ax = bgc_pkg::BGC_AX_IDLE;
      default:
        s_d.ax = bgc_pkg::BGC_AX_IDLE;
    endcase

    // dead-time divider
    s_d.div_cnt = s_q.div_cnt + 3'h1;

    // hall pin sync, change counts when stages two and three agree
    s_d.sync2 = sync1_q;
    s_d.sync3 = s_q.sync2;
    for (int k = 0; k < 3; k++)
      if (s_q.sync2[k] == s_q.sync3[k])
        s_d.hall_stable[k] = s_q.sync3[k];

    // noise filter sampled at the selected rate
    if (s_q.hall_filter_mode_reg[`BGC_FM_ON_BIT])
    begin
      if (s_q.rate_cnt >= (16'h0001 << s_q.hall_filter_mode_reg[3:0]) - 16'h0001)
      begin
        s_d.rate_cnt = 16'h0000;
        for (int k = 0; k < 3; k++)
        begin
          if (hall_src[k] == s_q.filtered[k])
            s_d.match_cnt[k] = 5'h00;
          else if (s_q.match_cnt[k] + 5'h01 >= s_q.hall_filter_match_count)
          begin
            s_d.filtered[k]  = hall_src[k];
            s_d.match_cnt[k] = 5'h00;
          end
          else
            s_d.match_cnt[k] = s_q.match_cnt[k] + 5'h01;
        end
      end
      else
        s_d.rate_cnt = s_q.rate_cnt + 16'h0001;
    end
    else
    begin
      s_d.filtered = hall_src;  // filter bypassed when off
      s_d.rate_cnt = 16'h0000;
      for (int k = 0; k < 3; k++)
        s_d.match_cnt[k] = 5'h00;
    end

    // hall delay: buffer one follows filtered each cycle, timer started on a filtered change, buffer two loads on match
    if (!s_q.hall_ctrl[`BGC_HC_DLY_BIT])
    begin
      s_d.buf_one = 3'h0;
      s_d.buf_two = 3'h0;
      s_d.tmr_run = 1'b0;
      s_d.tmr     = 16'h0000;
    end
    else
    begin
      s_d.buf_one = s_q.filtered;
      if (s_q.filtered != s_q.buf_one)
      begin
        s_d.tmr_run = 1'b1;
        s_d.tmr     = 16'h0000;
      end
      else if (s_q.tmr_run)
      begin
        if (s_q.tmr >= s_q.timer_compare_a)
        begin
          s_d.buf_two = s_q.buf_one;
          s_d.tmr_run = 1'b0;
        end
        else
          s_d.tmr = s_q.tmr + 16'h0001;
      end
    end
  end

  // single state register
  always_ff @(posedge MCLK or negedge rst_s_q)
  begin
    if (!rst_s_q)
    begin
      s_q                       <= '0;
      s_q.ax                    <= bgc_pkg::BGC_AX_IDLE;
      s_q.dead_time_setup       <= `BGC_RST_DEAD_TIME;
      s_q.gate_polarity_control <= `BGC_RST_POLARITY;
      s_q.hall_ctrl             <= `BGC_RST_HALL_CTRL;
      s_q.timer_compare_a       <= `BGC_RST_TIMER_CMP;
    end
    else
      s_q <= s_d;
  end

  // bus handshakes and outputs
  assign AWREADY = s_q.ax == bgc_pkg::BGC_AX_IDLE && !s_q.aw_got;
  assign WREADY  = s_q.ax == bgc_pkg::BGC_AX_IDLE && !s_q.w_got;
  assign ARREADY = s_q.ax == bgc_pkg::BGC_AX_IDLE && !wr_go;
  assign BVALID  = s_q.ax == bgc_pkg::BGC_AX_WRSP;
  assign RVALID  = s_q.ax == bgc_pkg::BGC_AX_RRSP;
  assign BRESP   = s_q.resp;
  assign RRESP   = s_q.resp;
  assign RDATA   = s_q.rdata;
  assign HALL_FILTERED         = s_q.hall_ctrl[`BGC_HC_DLY_BIT] ? s_q.buf_two : s_q.filtered;
  assign HALL_DELAY_BUFFER_ONE = s_q.buf_one;
  assign HALL_DELAY_BUFFER_TWO = s_q.buf_two;
  assign HALL_DECODER_ON       = s_q.hall_ctrl[`BGC_HC_DEC_ON_BIT];
  assign TIMER_DEDICATED       = s_q.hall_ctrl[`BGC_HC_DLY_BIT];
  assign TIMER_SEL             = s_q.hall_ctrl[`BGC_HC_TSEL_LSB +: 2];
  assign TIMER_RUN_BIT         = s_q.tmr_run;
endmodule
`default_nettype wire

// file: bgc_top_props.sv
`timescale 1ns/100ps
`default_nettype none
module bgc_top_props
(
  input wire logic        MCLK,
  input wire logic        NRST,
  input wire logic [11:0] AWADDR,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic [5:0]  PHASE_PRE,
  input wire logic [5:0]  GATE_OUT,
  input wire logic [5:0]  GATE_OE,
  input wire logic [2:0]  HALL_DELAY_BUFFER_ONE,
  input wire logic [2:0]  HALL_DELAY_BUFFER_TWO,
  input wire logic        HALL_DECODER_ON,
  input wire logic        TIMER_DEDICATED,
  input wire logic [1:0]  TIMER_SEL,
  input wire logic        TIMER_RUN_BIT
);
  logic [5:0] pol_q;
  logic [7:0] dt_q;
  logic       pol_seen_q;
  logic       hc_seen_q;
  logic [2:0] quiet_q;
  logic [9:0] run_q;
  logic [5:0] prev_q;
  // settings are trusted only a few cycles after the last write
  wire        wr = AWVALID && AWREADY && WVALID && WREADY;
  wire        sat = (quiet_q == 3'h7);
  wire        calm = sat && !wr;
  wire  [5:0] g = GATE_OUT ^ pol_q;
  wire  [5:0] stg = prev_q & ~{prev_q[4], prev_q[5], prev_q[2], prev_q[3], prev_q[0], prev_q[1]};
  wire  [9:0] dv = 10'h1 << dt_q[7:6];
  wire  [9:0] lo = ({5'h0, dt_q[4:0]} + 10'h1) * dv;
  // shadow of written settings, last phase and rise length
  always_ff @(posedge MCLK or negedge NRST)
    if (!NRST)
    begin
      pol_q      <= '0;
      dt_q       <= '0;
      pol_seen_q <= 1'b0;
      hc_seen_q  <= 1'b0;
      quiet_q    <= '0;
      run_q      <= '0;
      prev_q     <= '0;
    end
    else
    begin
      quiet_q    <= wr ? 3'h0 : (sat ? quiet_q : quiet_q + 3'h1);
      prev_q     <= PHASE_PRE;
      run_q      <= (PHASE_PRE[0] && !PHASE_PRE[1]) ? run_q + 10'h1 : 10'h0;
      dt_q       <= (wr && AWADDR == 12'h000) ? WDATA[7:0] : dt_q;
      pol_q      <= (wr && AWADDR == 12'h004) ? WDATA[5:0] : pol_q;
      pol_seen_q <= pol_seen_q | (wr && AWADDR == 12'h004);
      hc_seen_q  <= hc_seen_q | (wr && AWADDR == 12'h008);
    end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);
  a_fall_low: assert property (calm |-> (g & ~prev_q) == 6'h00)
    else $error("gate on one cycle after its phase was low");
  a_pass_thru: assert property (calm && !dt_q[5] |-> g == stg)
    else $error("gate differs from staggered phase with dead time off");
  a_no_shoot: assert property (calm |->
    (g & {g[4], g[5], g[2], g[3], g[0], g[1]}) == 6'h00)
    else $error("both gates of a pair on");
  // first dead-time period is partial: the divider runs free
  a_dt_delay: assert property (calm && dt_q[5] && $rose(g[0]) |->
    run_q >= lo - dv + 10'h2 && run_q <= lo + 10'h1)
    else $error("dead time length wrong");
  a_oe_off: assert property (!pol_seen_q |-> GATE_OE == 6'h00)
    else $error("gate pins driven after reset");
  a_oe_on: assert property (calm && pol_seen_q |-> GATE_OE == 6'h3f)
    else $error("gate pins not driven");
  a_buf_zero: assert property (!TIMER_DEDICATED [*2] |->
    (HALL_DELAY_BUFFER_ONE | HALL_DELAY_BUFFER_TWO) == 3'h0)
    else $error("delay buffers not cleared");
  a_run_off: assert property (!TIMER_DEDICATED [*2] |-> !TIMER_RUN_BIT)
    else $error("timer run driven while not dedicated");
  a_hall_rst: assert property (!hc_seen_q |->
    !TIMER_DEDICATED && !HALL_DECODER_ON && TIMER_SEL == 2'b00)
    else $error("hall control not at reset value");
  c_dt_rise: cover property (calm && dt_q[5] && $rose(g[0]));
  c_both_on: cover property (calm && PHASE_PRE[0] && PHASE_PRE[1]);
  c_delay_on: cover property (TIMER_DEDICATED);
endmodule
bind bgc_top bgc_top_props u_props (.MCLK, .NRST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WVALID,
  .WREADY, .PHASE_PRE, .GATE_OUT, .GATE_OE, .HALL_DELAY_BUFFER_ONE, .HALL_DELAY_BUFFER_TWO,
  .HALL_DECODER_ON, .TIMER_DEDICATED, .TIMER_SEL, .TIMER_RUN_BIT);
`default_nettype wire

// file: bgc_motor_model.sv
`timescale 1ns/100ps
`default_nettype none
module bgc_motor_model
(
  input  wire logic       clk,
  input  wire logic       step,
  input  wire logic [5:0] gate_out,
  input  wire logic [5:0] gate_oe,
  output logic [2:0]      hall,
  output logic [5:0]      gate_pin
);
  localparam logic [17:0] SEQ = {3'b101, 3'b100, 3'b110, 3'b010, 3'b011, 3'b001};
  logic [2:0] idx = 3'h0;
  // rotor moves one hall step per request, never skipping one
  always_ff @(posedge clk)
    if (step)
      idx <= (idx == 3'h5) ? 3'h0 : idx + 3'h1;
  // real sensors only, no comparator substitutes needing hysteresis
  assign hall = SEQ[idx * 3 +: 3];
  // released gate lines are pulled off by the driver stage
  assign gate_pin = gate_oe & gate_out;
endmodule
`default_nettype wire

// file: bgc_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module bgc_top_tb_top;
  logic        MCLK = 1'b0;
  logic        NRST = 1'b0;
  logic [11:0] AWADDR = '0;
  logic [11:0] ARADDR = '0;
  logic [31:0] WDATA = '0;
  logic [3:0]  WSTRB = 4'hf;
  logic        AWVALID = 1'b0;
  logic        WVALID = 1'b0;
  logic        BREADY = 1'b0;
  logic        ARVALID = 1'b0;
  logic        RREADY = 1'b0;
  logic [5:0]  PHASE_PRE = '0;
  logic        step = 1'b0;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, HALL_DECODER_ON, TIMER_DEDICATED;
  logic        TIMER_RUN_BIT;
  logic [1:0]  BRESP, RRESP, TIMER_SEL, r;
  logic [31:0] RDATA, seed, p;
  logic [2:0]  HALL_SENSOR_INPUTS, HALL_FILTERED, HALL_DELAY_BUFFER_ONE, HALL_DELAY_BUFFER_TWO;
  logic [5:0]  GATE_OUT, GATE_OE, gate_pin, pol;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          i, n, lo;
  bgc_top uut (.MCLK, .NRST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
    .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
    .PHASE_PRE, .HALL_SENSOR_INPUTS, .GATE_OUT, .GATE_OE, .HALL_FILTERED, .HALL_DELAY_BUFFER_ONE,
    .HALL_DELAY_BUFFER_TWO, .HALL_DECODER_ON, .TIMER_DEDICATED, .TIMER_SEL, .TIMER_RUN_BIT);
  bgc_motor_model u_motor (.clk(MCLK), .step(step), .gate_out(GATE_OUT), .gate_oe(GATE_OE),
    .hall(HALL_SENSOR_INPUTS), .gate_pin(gate_pin));
  // 200 MHz clock
  initial
  begin
    forever #2.5 MCLK = ~MCLK;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [5:0] stg(input logic [5:0] v);
    return v & ~{v[4], v[5], v[2], v[3], v[0], v[1]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one write: address and data offered together, response awaited
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    logic aw, w, b;
    int k;
    @(posedge MCLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    k = 0;
    while (b && k < 1000)
    begin
      @(posedge MCLK);
      k++;
      if (!aw && !w && BVALID)
      begin
        r = BRESP;
        b = 1'b0;
        BREADY <= 1'b0;
      end
      if (aw && AWREADY)
      begin
        aw = 1'b0;
        AWVALID <= 1'b0;
      end
      if (w && WREADY)
      begin
        w = 1'b0;
        WVALID <= 1'b0;
      end
    end
    if (b)
      chk(32'h0, 32'h1);
  endtask
  // one read, then compare data and response
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar, rd;
    int k;
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    ar = 1'b1;
    rd = 1'b1;
    k = 0;
    while (rd && k < 1000)
    begin
      @(posedge MCLK);
      k++;
      if (!ar && RVALID)
      begin
        chk(RDATA, e);
        chk(32'(RRESP), 32'(er));
        rd = 1'b0;
        RREADY <= 1'b0;
      end
      if (ar && ARREADY)
      begin
        ar = 1'b0;
        ARVALID <= 1'b0;
      end
    end
    if (rd)
      chk(32'h0, 32'h1);
  endtask
  task automatic waith(input logic [2:0] e);
    n = 0;
    while (HALL_FILTERED !== e && n < 300)
    begin
      @(posedge MCLK);
      #1 n++;
    end
    chk(32'(HALL_FILTERED), 32'(e));
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog
  initial
  begin
    repeat (50000) @(posedge MCLK);
    error_cnt++;
    finish_test();
  end
  // main sequence
  initial
  begin
    seed = 32'hc13fdc10;
    repeat (3) @(posedge MCLK);
    NRST <= 1'b1;
    repeat (4) @(posedge MCLK);
    rdchk(12'h000, 32'h0, 2'b00);
    rdchk(12'h004, 32'h0, 2'b00);
    rdchk(12'h008, 32'h10, 2'b00);
    rdchk(12'h040, 32'h0, 2'b10);
    axw(12'h018, 32'h0);
    chk(32'(r), 32'h2);
    chk(32'(gate_pin | GATE_OE), 32'h0);
    $display("test reset done");
    p = rnd();
    pol = p[5:0];
    axw(12'h004, 32'(pol));
    rdchk(12'h004, 32'(pol), 2'b00);
    for (i = 0; i < 40; i++)
    begin
      p = rnd();
      @(posedge MCLK);
      PHASE_PRE <= p[5:0];
      @(posedge MCLK);
      #1 chk(32'(GATE_OUT), 32'(stg(p[5:0]) ^ pol));
    end
    chk(32'(GATE_OE), 32'h3f);
    $display("test polarity done");
    for (i = 0; i < 4; i++)
    begin
      p = rnd();
      @(posedge MCLK);
      PHASE_PRE <= 6'h00;
      axw(12'h000, {24'h0, i[1:0], 1'b1, p[4:0]});
      repeat (8) @(posedge MCLK);
      PHASE_PRE <= 6'h01;
      n = 0;
      #1;
      while ((GATE_OUT[0] ^ pol[0]) !== 1'b1 && n < 400)
      begin
        @(posedge MCLK);
        #1 n++;
      end
      // count+1 ticks, the first one partial, plus one register cycle
      lo = int'(p[4:0]) << i;
      chk(32'(n >= lo + 2 && n <= lo + (1 << i) + 1), 32'h1);
    end
    @(posedge MCLK);
    PHASE_PRE <= 6'h00;
    axw(12'h000, 32'h3f);
    repeat (8) @(posedge MCLK);
    PHASE_PRE <= 6'h01;
    repeat (4) @(posedge MCLK);
    PHASE_PRE <= 6'h00;
    n = 0;
    repeat (40)
    begin
      @(posedge MCLK);
      #1 n += int'(GATE_OUT[0] ^ pol[0]);
    end
    chk(n, 32'h0);
    $display("test dead time done");
    axw(12'h010, 32'h10);
    axw(12'h014, 32'h02);
    axw(12'h00c, 32'h05);
    waith(3'h5);
    axw(12'h008, 32'h18);
    for (i = 0; i < 6; i++)
    begin
      @(posedge MCLK);
      step <= 1'b1;
      @(posedge MCLK);
      step <= 1'b0;
      #1 waith(HALL_SENSOR_INPUTS);
    end
    axw(12'h01c, 32'h0004);
    axw(12'h008, 32'h78);
    chk(32'({TIMER_DEDICATED, TIMER_SEL}), 32'h5);
    // each hall step runs the timer from zero to the compare value
    repeat (3)
    begin
      repeat (12) @(posedge MCLK);
      step <= 1'b1;
      @(posedge MCLK);
      step <= 1'b0;
      n = 0;
      repeat (20)
      begin
        @(posedge MCLK);
        #1 n += int'(TIMER_RUN_BIT);
      end
      chk(n, 32'h5);
      chk(32'(HALL_FILTERED), 32'(HALL_SENSOR_INPUTS));
    end
    axw(12'h008, 32'h79);
    chk(32'(HALL_DECODER_ON), 32'h1);
    axw(12'h008, 32'h18);
    repeat (2) @(posedge MCLK);
    #1 chk(32'({HALL_DELAY_BUFFER_ONE, HALL_DELAY_BUFFER_TWO}), 32'h0);
    $display("test hall done");
    finish_test();
  end
endmodule
`default_nettype wire
